/* src/scp_pkg.sv */
// Summary of operation
// R1 - Select low: accept shift clock and data
// R2 - Select high: ignore shift clock and data
// R3 - Sample data on rising edge, falling if strap
// R4 - Change status on falling edge, rising if strap
// R5 - Select low: shift out each channel status
// R6 - Select high: status output high impedance
// R7 - Command pending low while processing command
// R8 - Host sends commands only while pending high
// R9 - Reset low returns device to initial state
// R10 - After reset, halt and enter power-down
// R11 - ROM-disable strap high disables ROM interface
// R12 - ROM select low only during ROM access
// R13 - Pending low in reset, high in power-down
// R14 - Reset/power-down: status Hi-Z, ROM outputs high
// R15 - Synchronise host pins before edge detection
package scp_pkg;

  // =====================================================
  // Sizes
  // =====================================================
  localparam int SCP_CMD_W = 8;   // Bits per command word
  localparam int SCP_CH = 4;      // Playback channels reported
  localparam int SCP_SYNC_W = 7;  // Synchronised pin count

  // =====================================================
  // Synchroniser bit positions
  // =====================================================
  localparam int SCP_IX_SEL = 0;
  localparam int SCP_IX_SCK = 1;
  localparam int SCP_IX_SI = 2;
  localparam int SCP_IX_EDGE = 3;
  localparam int SCP_IX_ROMDIS = 4;
  localparam int SCP_IX_RST = 5;
  localparam int SCP_IX_ROMIN = 6;

  // =====================================================
  // Reset values
  // =====================================================
  // Select idle high, pin reset held active, rest low
  localparam logic [SCP_SYNC_W-1:0] SCP_SYNC_RST = 7'h01;
  localparam logic SCP_ROM_IDLE = 1'b1;  // ROM pins idle level

  // =====================================================
  // Device states
  // =====================================================
  typedef enum logic [1:0] {
    SCP_ST_RESET = 2'b00,  // Reset pin held low
    SCP_ST_PDOWN = 2'b01,  // Halted after reset
    SCP_ST_IDLE = 2'b10,   // Ready for a command
    SCP_ST_BUSY = 2'b11    // Processing a command
  } scp_state_e;

endpackage

/* src/scp_port.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Serial command port pin logic
// =====================================================
module scp_port
  import scp_pkg::*;
#(
  parameter int CMD_W = SCP_CMD_W,
  parameter int CH = SCP_CH
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reset_n,
  input wire logic host_select_n,
  input wire logic shift_clock,
  input wire logic serial_in,
  output logic status_out,
  output logic status_oe,
  output logic cmd_pending_n,
  input wire logic edge_polarity_strap,
  input wire logic ext_rom_disable,
  output logic rom_select_n,
  output logic rom_shift_clock,
  output logic rom_data_out,
  input wire logic rom_data_in,
  output logic [CMD_W-1:0] cmd_data,
  output logic cmd_valid,
  input wire logic cmd_done,
  input wire logic [CH-1:0] channel_status,
  input wire logic rom_req,
  input wire logic rom_clk_core,
  input wire logic rom_mosi_core,
  output logic rom_miso,
  output logic rom_enabled,
  output logic powered_down
);

  // =====================================================
  // Declarations
  // =====================================================
  logic [SCP_SYNC_W-1:0] pins_s;   // Synchronised pins
  logic sel_s;                     // Select, active low
  logic sck_s;                     // Shift clock
  logic si_s;                      // Serial data
  logic edge_s;                    // Edge polarity strap
  logic romdis_s;                  // ROM disable strap
  logic rst_s;                     // Reset pin, active low
  logic sck_d;                     // Previous shift clock
  logic sck_rise;                  // Rising shift clock edge
  logic sck_fall;                  // Falling shift clock edge
  logic sample_edge;               // Edge that takes data
  logic drive_edge;                // Edge that moves status
  scp_state_e state;               // Device state
  scp_state_e next_state;          // Next device state
  logic [CMD_W-1:0] rx_shift;      // Incoming bits
  logic [$clog2(CMD_W+1)-1:0] rx_cnt; // Bits received
  logic rx_last;                   // Final bit of a word
  logic [CH-1:0] so_shift;         // Outgoing status bits
  logic active;                    // Out of reset and power-down

  // =====================================================
  // Pin synchronisation
  // =====================================================
  // All host and strap pins pass two flops [R15]
  scp_sync #(
    .WIDTH(SCP_SYNC_W),
    .RST_VAL(SCP_SYNC_RST)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({rom_data_in, reset_n, ext_rom_disable, edge_polarity_strap,
               serial_in, shift_clock, host_select_n}),
    .sync_out(pins_s)
  );

  assign sel_s = pins_s[SCP_IX_SEL];
  assign sck_s = pins_s[SCP_IX_SCK];
  assign si_s = pins_s[SCP_IX_SI];
  assign edge_s = pins_s[SCP_IX_EDGE];
  assign romdis_s = pins_s[SCP_IX_ROMDIS];
  assign rst_s = pins_s[SCP_IX_RST];
  assign rom_miso = pins_s[SCP_IX_ROMIN];

  // =====================================================
  // Shift clock edge detection
  // =====================================================
  // Last synchronised shift clock level
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sck_d <= 1'b0;
    else
      sck_d <= sck_s;
  end

  assign sck_rise = sck_s && !sck_d;
  assign sck_fall = !sck_s && sck_d;
  // Edges only count while selected [R1] [R2]
  assign sample_edge = !sel_s && (edge_s ? sck_fall : sck_rise); // [R3]
  assign drive_edge = !sel_s && (edge_s ? sck_rise : sck_fall);  // [R4]
  assign rx_last = sample_edge && (rx_cnt == ($clog2(CMD_W+1))'(CMD_W-1));

  // =====================================================
  // Device state
  // =====================================================
  // Next state from reset pin, commands and completion
  always_comb
  begin
    next_state = state;
    if (!rst_s)
      next_state = SCP_ST_RESET;                       // [R9]
    else
    begin
      unique case (state)
        SCP_ST_RESET: next_state = SCP_ST_PDOWN;       // [R10]
        SCP_ST_PDOWN: if (rx_last) next_state = SCP_ST_BUSY;
        SCP_ST_IDLE: if (rx_last) next_state = SCP_ST_BUSY;
        SCP_ST_BUSY: if (cmd_done) next_state = SCP_ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= SCP_ST_RESET;
    else
      state <= next_state;
  end

  assign active = state[1];
  assign powered_down = (state == SCP_ST_PDOWN);
  // Low in reset and busy, high otherwise [R7] [R13]
  assign cmd_pending_n = (state == SCP_ST_PDOWN) || (state == SCP_ST_IDLE);

  // =====================================================
  // Command reception
  // =====================================================
  // Shift in on sample edges, count restarts when deselected
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_shift <= '0;
      rx_cnt <= '0;
    end
    else if (sel_s || !rst_s)
      rx_cnt <= '0;                                    // [R2]
    else if (sample_edge)
    begin
      rx_shift <= {rx_shift[CMD_W-2:0], si_s};         // [R1] [R3]
      rx_cnt <= rx_last ? '0 : rx_cnt + 1'b1;
    end
  end

  // Hand a whole word to the core unless busy or in reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmd_data <= '0;
      cmd_valid <= 1'b0;
    end
    else
    begin
      cmd_valid <= rx_last && rst_s && (state != SCP_ST_BUSY) && (state != SCP_ST_RESET);
      if (rx_last)
        cmd_data <= {rx_shift[CMD_W-2:0], si_s};
    end
  end

  // =====================================================
  // Status output
  // =====================================================
  // Load while deselected, shift on drive edges [R5]
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      so_shift <= '0;
    else if (sel_s)
      so_shift <= channel_status;
    else if (drive_edge)
      so_shift <= {so_shift[CH-2:0], 1'b0};            // [R4]
  end

  assign status_out = so_shift[CH-1];
  // Driven only while selected and running [R6] [R14]
  assign status_oe = !sel_s && active;

  // =====================================================
  // External ROM interface
  // =====================================================
  assign rom_enabled = !romdis_s;                      // [R11]

  // ROM pins follow the core only during an access [R12]
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rom_select_n <= SCP_ROM_IDLE;
      rom_shift_clock <= SCP_ROM_IDLE;
      rom_data_out <= SCP_ROM_IDLE;
    end
    else if (rom_req && !romdis_s && active && rst_s)  // [R11]
    begin
      rom_select_n <= 1'b0;
      rom_shift_clock <= rom_clk_core;
      rom_data_out <= rom_mosi_core;
    end
    else
    begin
      rom_select_n <= SCP_ROM_IDLE;                    // [R14]
      rom_shift_clock <= SCP_ROM_IDLE;
      rom_data_out <= SCP_ROM_IDLE;
    end
  end

  // =====================================================
  // Assertions
  // =====================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_sel_ignore;
    sel_s |=> $stable(rx_shift) && !cmd_valid;
  endproperty
  a_sel_ignore: assert property (p_sel_ignore) else $error("data taken while deselected"); // [R2]

  property p_sample;
    sample_edge |=> rx_shift[0] == $past(si_s);
  endproperty
  a_sample: assert property (p_sample) else $error("data bit not sampled"); // [R1] [R3]

  property p_edge_pick;
    (!sel_s && sck_rise) |-> (sample_edge == !edge_s) && (drive_edge == edge_s);
  endproperty
  a_edge_pick: assert property (p_edge_pick) else $error("wrong edge for strap"); // [R3] [R4]

  property p_so_move;
    $changed(status_out) && !$past(sel_s) && !sel_s |-> $past(drive_edge);
  endproperty
  a_so_move: assert property (p_so_move) else $error("status moved off drive edge"); // [R4] [R5]

  // Pin level two clocks back, seen through the synchroniser
  property p_so_hiz;
    $past(host_select_n, 2) |-> !status_oe;
  endproperty
  a_so_hiz: assert property (p_so_hiz) else $error("status driven while deselected"); // [R6]

  property p_busy;
    cmd_valid |-> !cmd_pending_n ##1 (!cmd_pending_n || $past(cmd_done) || !rst_s);
  endproperty
  a_busy: assert property (p_busy) else $error("pending not low while busy"); // [R7]

  property p_reset;
    !rst_s |=> state == SCP_ST_RESET && !cmd_pending_n;
  endproperty
  a_reset: assert property (p_reset) else $error("reset pin not obeyed"); // [R9] [R13]

  property p_pdown;
    (state == SCP_ST_RESET) && rst_s |=> powered_down ##0 cmd_pending_n;
  endproperty
  a_pdown: assert property (p_pdown) else $error("no power-down after reset"); // [R10] [R13]

  property p_rom_dis;
    romdis_s |=> rom_select_n;
  endproperty
  a_rom_dis: assert property (p_rom_dis) else $error("rom used while disabled"); // [R11]

  property p_rom_sel;
    !rom_select_n |-> $past(rom_req) && $past(active);
  endproperty
  a_rom_sel: assert property (p_rom_sel) else $error("rom select without access"); // [R12]

  property p_idle_pins;
    !active |-> !status_oe && rom_select_n && rom_shift_clock && rom_data_out;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("pins not idle in halt"); // [R14]

endmodule
`default_nettype wire

/* src/scp_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Two-stage synchroniser for a group of pins
// =====================================================
module scp_sync
  import scp_pkg::*;
#(
  parameter int WIDTH = SCP_SYNC_W,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1; // First stage, read only by second

  // Two flops in series, constant reset values
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

/* test/scp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Host side of the serial command port
// =====================================================
module scp_host_model
(
  input wire logic clk,
  input wire logic strap,
  input wire logic so_pin,
  output logic sel_n,
  output logic sck,
  output logic sdi
);
  localparam int HALF = 4; // Half of 200 ns in clk cycles

  // Idle: deselected, clock low
  initial
  begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end

  // One word, MSB first; status read at the first four sample edges
  task automatic xfer(input logic [7:0] cmd, output logic [3:0] st);
    int i;
    begin
      sck <= strap; // Idle level, so selecting makes no edge
      @(posedge clk);
      sel_n <= 1'b0;
      sdi <= cmd[7];
      repeat (2 * HALF) @(posedge clk);
      for (i = 0; i < 8; i++)
      begin
        sck <= ~strap; // Sample edge
        if (i < 4)
          st[3 - i] = so_pin;
        repeat (HALF) @(posedge clk);
        sck <= strap; // Drive edge
        if (i < 7)
          sdi <= cmd[6 - i];
        repeat (HALF) @(posedge clk);
      end
      sel_n <= 1'b1;
      sdi <= ~sdi; // Released line shows no stale bit
    end
  endtask

  // Clock and data toggling while deselected
  task automatic noise(input int n);
    repeat (n)
    begin
      sck <= ~sck;
      sdi <= ~sdi;
      repeat (HALF) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* test/tb_scp_port.sv */
`timescale 1ns/10ps
`default_nettype none
// =====================================================
// Pin-level bench of the serial command port
// =====================================================
module tb_scp_port;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reset_n = 1'b1;
  logic strap = 1'b0;
  logic rom_dis = 1'b0;
  logic rom_din = 1'b0;
  logic cmd_done = 1'b0;
  logic [3:0] ch_st = 4'h0;
  logic rom_req = 1'b1;
  logic rom_clk = 1'b0;
  logic rom_mosi = 1'b0;
  logic sel_n, sck, sdi, so, so_oe, pend_n, rsel_n, rsck, rdo, miso, rom_en, pdn, cvalid;
  logic [7:0] cdata;
  logic [7:0] got = 8'h00;
  logic [3:0] st;
  wire so_pin = so_oe ? so : 1'bz; // Pin as the host sees it
  int n_errors = 0;
  int tests_run = 0;
  int n_words = 0;

  always #12.5 clk = ~clk;

  scp_port i_scp_port (.clk(clk), .arst_n(arst_n), .reset_n(reset_n), .host_select_n(sel_n),
    .shift_clock(sck), .serial_in(sdi), .status_out(so), .status_oe(so_oe), .cmd_pending_n(pend_n),
    .edge_polarity_strap(strap), .ext_rom_disable(rom_dis), .rom_select_n(rsel_n),
    .rom_shift_clock(rsck), .rom_data_out(rdo), .rom_data_in(rom_din), .cmd_data(cdata),
    .cmd_valid(cvalid), .cmd_done(cmd_done), .channel_status(ch_st), .rom_req(rom_req),
    .rom_clk_core(rom_clk), .rom_mosi_core(rom_mosi), .rom_miso(miso), .rom_enabled(rom_en),
    .powered_down(pdn));

  scp_host_model i_scp_host_model (.clk(clk), .strap(strap), .so_pin(so_pin), .sel_n(sel_n),
    .sck(sck), .sdi(sdi));

  // Latch each accepted word
  always @(posedge clk)
    if (cvalid === 1'b1)
    begin
      got <= cdata;
      n_words <= n_words + 1;
    end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        n_errors++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task automatic end_of_test();
    begin
      $display("Mismatches %0d, comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task automatic fail_wait();
    begin
      n_errors++;
      $display("[ERR] %0t wait ran out", $time);
      end_of_test();
    end
  endtask

  task automatic wait_pend(input logic v);
    int k;
    begin
      for (k = 0; k < 40 && pend_n !== v; k++)
        @(posedge clk) #1;
      if (pend_n !== v)
        fail_wait();
    end
  endtask

  task automatic wait_word(input int n0);
    int k;
    begin
      for (k = 0; k < 40 && n_words == n0; k++)
        @(posedge clk) #1;
      if (n_words == n0)
        fail_wait();
    end
  endtask

  // Core finishes; pending rises next cycle
  task automatic done_pulse();
    begin
      @(posedge clk);
      cmd_done <= 1'b1;
      @(posedge clk);
      cmd_done <= 1'b0;
      @(posedge clk) #1;
      check(pend_n, 1'b1);
    end
  endtask

  // Word in power-down wakes; ROM pins follow the core
  task automatic t_wake();
    int n0;
    begin
      n0 = n_words;
      i_scp_host_model.xfer(8'h81, st);
      check(st, 4'hz);
      wait_word(n0);
      check(got, 8'h81);
      check({pend_n, pdn}, 2'h0);
      repeat (2) @(posedge clk);
      rom_clk <= 1'b1;
      rom_din <= 1'b1;
      repeat (3) @(posedge clk) #1;
      check({rsel_n, rsck, rdo, miso}, 4'h5);
      @(posedge clk);
      rom_dis <= 1'b1;
      repeat (4) @(posedge clk) #1;
      check({rsel_n, rsck, rdo, rom_en}, 4'hE);
      @(posedge clk);
      rom_dis <= 1'b0;
      rom_req <= 1'b0;
      repeat (4) @(posedge clk) #1;
      check({rsel_n, rom_en, pend_n}, 3'h6);
      done_pulse();
    end
  endtask

  // Toggling while deselected takes nothing
  task automatic t_desel();
    int n0;
    begin
      n0 = n_words;
      @(posedge clk);
      i_scp_host_model.noise(24);
      #1;
      check(so_oe, 1'b0);
      repeat (6) @(posedge clk) #1;
      check(8'(n_words - n0), 8'h00);
    end
  endtask

  // Framed word under a given strap
  task automatic t_frame(input logic s, input logic [7:0] c, input logic [3:0] cs);
    int n0;
    begin
      @(posedge clk);
      strap <= s;
      ch_st <= cs;
      repeat (4) @(posedge clk);
      wait_pend(1'b1);
      n0 = n_words;
      i_scp_host_model.xfer(c, st);
      check(st, cs);
      wait_word(n0);
      check(got, c);
      done_pulse();
    end
  endtask

  // Reset pin mid-run, then power-down
  task automatic t_reset_pin();
    begin
      @(posedge clk);
      reset_n <= 1'b0;
      rom_req <= 1'b1;
      repeat (5) @(posedge clk) #1;
      check({pend_n, pdn, so_oe}, 3'b000);
      check({rsel_n, rsck, rdo}, 3'h7);
      @(posedge clk);
      reset_n <= 1'b1;
      wait_pend(1'b1);
      check({pdn, rsel_n, rsck, rdo}, 4'hF);
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk) #1;
    check(pend_n, 1'b0);
    check({so_oe, rsel_n, rsck, rdo}, 4'h7);
    @(posedge clk);
    arst_n <= 1'b1;
    wait_pend(1'b1);
    check({pdn, rsel_n, rsck, rdo}, 4'hF);
    t_wake();
    t_desel();
    t_frame(1'b0, 8'hA5, 4'hA);
    t_frame(1'b1, 8'h3C, 4'h6);
    t_reset_pin();
    end_of_test();
  end
endmodule
`default_nettype wire
